// file: core/msd_pkg.sv
package msd_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned BLANK_TICK_NS = 102_400;
  localparam int unsigned BLANK_TICK_CYC = BLANK_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MIN_US = 5_000;
  // Code 0 still blanks for about 5 ms
  localparam logic [16:0] BLANK_BASE_TICKS = 17'((BLANK_MIN_US * 1000) / BLANK_TICK_NS);
  localparam int unsigned SAMPLE_HZ = 80_000;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned PWM_FAST_HZ = 50_000;
  localparam int unsigned PWM_SLOW_HZ = 25_000;
  localparam logic [9:0] PWM_FAST_CYC = 10'(CLK_HZ / PWM_FAST_HZ);
  localparam logic [9:0] PWM_SLOW_CYC = 10'(CLK_HZ / PWM_SLOW_HZ);

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INRUSH = 8'h04;
  localparam logic [7:0] ADDR_TARGET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;

  // Field positions
  localparam int CMD_CLEAR_FAULT_BIT = 0;
  localparam int TARGET_DUTY_LSB = 8;

  // Values after reset (inrush code gives about 1 s)
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] INRUSH_RESET = 16'h25F5;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [5:0] DUTY_PROG_RESET = 6'h00;
  localparam logic [7:0] DUTY_MAX = 8'hFF;

  // Regulation and current limit mode codes
  localparam logic [1:0] REG_SPEED = 2'b10;
  localparam logic [1:0] REG_VOLTAGE = 2'b11;
  localparam logic [1:0] ILIM_OFF = 2'b00;
  localparam logic [1:0] ILIM_INRUSH = 2'b01;

  // Control register layout, MSB first
  typedef struct packed {
    logic [1:0] output_filter_cutoff;
    logic pwm_input_mode;
    logic reg_direction_in_b;
    logic reg_direction_in_a;
    logic bridge_control_source;
    logic manual_duty;
    logic pwm_rate_select;
    logic [1:0] reg_mode;
    logic [1:0] current_limit_mode;
    logic stall_report_enable;
    logic stall_response_select;
    logic int_ref_sel;
    logic stall_en;
  } msd_ctrl_s;

  // Bridge switch commands
  typedef struct packed {
    logic hs_a;
    logic ls_a;
    logic hs_b;
    logic ls_b;
  } msd_bridge_s;

  typedef enum logic [2:0] {
    ST_BLANK = 3'b001,
    ST_ARMED = 3'b010,
    ST_LATCHED = 3'b100
  } msd_state_e;
endpackage

// file: core/msd_core.sv
`timescale 1ns/1ps
`default_nettype none

module msd_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sense_ge_ext_ref,
  input wire logic sense_ge_int_ref,
  input wire logic direction_pin_a,
  input wire logic direction_pin_b,
  input wire logic target_over_supply,
  input wire logic [7:0] avg_voltage,
  input wire logic [7:0] speed_estimate,
  input wire logic fault_recovered,
  input wire logic sleep_exit,
  output msd_pkg::msd_bridge_s bridge_outputs,
  output logic fault_out_n_o,
  output logic fault_out_n_oe,
  output logic [1:0] output_filter_cutoff
);

  localparam int NSYNC = 5;

  msd_pkg::msd_ctrl_s ctrl_reg;
  logic [15:0] inrush_reg;
  logic [7:0] target_reg;
  logic [5:0] duty_prog_reg;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  logic cmp_sel, pin_a, pin_b, over_sup;
  logic wr_en, clear_req;
  msd_pkg::msd_state_e state_reg;
  logic stall_reg;
  logic [11:0] tick_cnt_reg;
  logic [16:0] blank_cnt_reg;
  logic restart;
  logic [9:0] sample_cnt_reg;
  logic sample_tick;
  logic reg_active, full_duty;
  logic [7:0] duty_reg, measure, duty_eff;
  logic [9:0] pwm_cnt_reg, period;
  logic [17:0] on_cycles;
  logic pwm_on, internal_pwm, ilim_active;
  logic dir_a, dir_b;
  msd_pkg::msd_bridge_s drive_on, bridge_next;

  // Bridge decode shared by direct and PWM paths; inputs in IN/IN form
  function automatic msd_pkg::msd_bridge_s drive_f(input logic a, input logic b);
    msd_pkg::msd_bridge_s d;
    d = '0;
    case ({a, b})
      2'b10: begin
        d.hs_a = 1'b1;
        d.ls_b = 1'b1;
      end
      2'b01: begin
        d.hs_b = 1'b1;
        d.ls_a = 1'b1;
      end
      2'b11: begin
        d.ls_a = 1'b1;
        d.ls_b = 1'b1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  // Three-stage pin synchronisers; a change is taken once stages two and three agree
  assign pin_raw = {target_over_supply, direction_pin_b, direction_pin_a,
                    sense_ge_int_ref, sense_ge_ext_ref};
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          sync3_reg[i] <= 1'b0;
          pin_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= pin_raw[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
          if (sync2_reg[i] == sync3_reg[i]) begin
            pin_reg[i] <= sync3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign cmp_sel = ctrl_reg.int_ref_sel ? pin_reg[1] : pin_reg[0];
  assign pin_a = pin_reg[2];
  assign pin_b = pin_reg[3];
  assign over_sup = pin_reg[4];

  // APB: zero wait states, pready raised in the access cycle
  assign wr_en = psel && penable && pready && pwrite;
  assign clear_req = wr_en && (paddr == msd_pkg::ADDR_CMD) &&
                     pwdata[msd_pkg::CMD_CLEAR_FAULT_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          msd_pkg::ADDR_CTRL: prdata <= {16'h0000, ctrl_reg};
          msd_pkg::ADDR_INRUSH: prdata <= {16'h0000, inrush_reg};
          msd_pkg::ADDR_TARGET: prdata <= {18'h00000, duty_prog_reg, target_reg};
          msd_pkg::ADDR_STATUS: prdata <= {16'h0000, reg_active ? duty_reg : 8'h00,
                                           5'h00, reg_active, state_reg == msd_pkg::ST_BLANK,
                                           stall_reg};
          msd_pkg::ADDR_CMD: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= msd_pkg::CTRL_RESET;
      inrush_reg <= msd_pkg::INRUSH_RESET;
      target_reg <= msd_pkg::TARGET_RESET;
      duty_prog_reg <= msd_pkg::DUTY_PROG_RESET;
    end else if (wr_en) begin
      case (paddr)
        msd_pkg::ADDR_CTRL: ctrl_reg <= pwdata[15:0];
        msd_pkg::ADDR_INRUSH: inrush_reg <= pwdata[15:0];
        msd_pkg::ADDR_TARGET: begin
          target_reg <= pwdata[7:0];
          duty_prog_reg <= pwdata[msd_pkg::TARGET_DUTY_LSB +: 6];
        end
        default: ;
      endcase
    end
  end

  // Blanking restart sources; reset itself loads the window
  assign restart = clear_req || fault_recovered || sleep_exit;

  // Blanking timer on a 102.4 us tick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 12'h000;
      // Power-up opens a full default window, not a single tick
      blank_cnt_reg <= {1'b0, msd_pkg::INRUSH_RESET} + msd_pkg::BLANK_BASE_TICKS;
    end else if (restart || (state_reg != msd_pkg::ST_BLANK)) begin
      tick_cnt_reg <= 12'h000;
      // Window is code plus the 5 ms floor
      blank_cnt_reg <= {1'b0, inrush_reg} + msd_pkg::BLANK_BASE_TICKS;
    end else if (tick_cnt_reg == 12'(msd_pkg::BLANK_TICK_CYC - 1)) begin
      tick_cnt_reg <= 12'h000;
      if (blank_cnt_reg != 17'h00000) begin
        blank_cnt_reg <= blank_cnt_reg - 17'h00001;
      end
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 12'h001;
    end
  end

  // Stall state: the counter reloads whenever not blanking, so entry is a fresh window
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= msd_pkg::ST_BLANK;
    end else begin
      case (state_reg)
        msd_pkg::ST_BLANK: begin
          // Expiry arms the detector
          // Arm at the end of the last loaded tick, so the window is exactly the load
          if (!restart && blank_cnt_reg <= 17'h00001 &&
              tick_cnt_reg == 12'(msd_pkg::BLANK_TICK_CYC - 1)) begin
            state_reg <= msd_pkg::ST_ARMED;
          end
        end
        msd_pkg::ST_ARMED: begin
          if (restart) begin
            state_reg <= msd_pkg::ST_BLANK;
          end else if (ctrl_reg.stall_en && cmp_sel && !ctrl_reg.stall_response_select) begin
            state_reg <= msd_pkg::ST_LATCHED;
          end
        end
        msd_pkg::ST_LATCHED: begin
          if (clear_req) begin
            state_reg <= msd_pkg::ST_BLANK;
          end
        end
        default: state_reg <= msd_pkg::ST_BLANK;
      endcase
    end
  end

  // Stall flag; a fresh detection wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_reg <= 1'b0;
    // Set on first compare once armed
    end else if (state_reg == msd_pkg::ST_ARMED && ctrl_reg.stall_en && cmp_sel) begin
      stall_reg <= 1'b1;
    end else if (clear_req) begin
      stall_reg <= 1'b0;
    end
  end

  // Open-drain fault output, enable high while pulling low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_out_n_oe <= 1'b0;
    end else begin
      fault_out_n_oe <= stall_reg && ctrl_reg.stall_report_enable;
    end
  end
  assign fault_out_n_o = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_filter_cutoff <= 2'b00;
    end else begin
      output_filter_cutoff <= ctrl_reg.output_filter_cutoff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_cnt_reg <= 10'h000;
    end else if (sample_tick) begin
      sample_cnt_reg <= 10'h000;
    end else begin
      sample_cnt_reg <= sample_cnt_reg + 10'h001;
    end
  end
  assign sample_tick = (sample_cnt_reg == 10'(msd_pkg::SAMPLE_CYC - 1));

  // Mode 10 follows speed, 11 follows voltage
  assign reg_active = ctrl_reg.reg_mode[1];
  assign measure = (ctrl_reg.reg_mode == msd_pkg::REG_SPEED) ? speed_estimate : avg_voltage;
  // In voltage mode, target above supply forces full duty
  assign full_duty = (ctrl_reg.reg_mode == msd_pkg::REG_VOLTAGE) && over_sup;

  // Integrating loop: one step per sample keeps the slew bounded
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      duty_reg <= 8'h00;
    end else if (!reg_active) begin
      duty_reg <= 8'h00;
    end else if (full_duty) begin
      duty_reg <= msd_pkg::DUTY_MAX;
    end else if (sample_tick) begin
      if (measure < target_reg && duty_reg != msd_pkg::DUTY_MAX) begin
        duty_reg <= duty_reg + 8'h01;
      end else if (measure > target_reg && duty_reg != 8'h00) begin
        duty_reg <= duty_reg - 8'h01;
      end
    end
  end

  assign period = ctrl_reg.pwm_rate_select ? msd_pkg::PWM_SLOW_CYC : msd_pkg::PWM_FAST_CYC;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt_reg <= 10'h000;
    end else if (pwm_cnt_reg >= period - 10'h001) begin
      pwm_cnt_reg <= 10'h000;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
    end
  end

  // Manual duty widened from six bits
  assign internal_pwm = reg_active || ctrl_reg.manual_duty;
  assign duty_eff = reg_active ? duty_reg : {duty_prog_reg, duty_prog_reg[5:4]};
  assign on_cycles = 18'(duty_eff) * 18'(period);
  assign pwm_on = (duty_eff == msd_pkg::DUTY_MAX) || (pwm_cnt_reg < on_cycles[17:8]);

  // Direction source in manual mode; regulation uses pins
  always_comb begin
    if (!reg_active && ctrl_reg.manual_duty && ctrl_reg.bridge_control_source) begin
      dir_a = ctrl_reg.reg_direction_in_a;
      dir_b = ctrl_reg.reg_direction_in_b;
    // Plain bridge: input mode 0 treats pins as enable and phase
    end else if (!internal_pwm && !ctrl_reg.pwm_input_mode) begin
      dir_a = pin_a && !pin_b;
      dir_b = pin_a && pin_b;
    end else begin
      dir_a = pin_a;
      dir_b = pin_b;
    end
  end

  always_comb begin
    case (ctrl_reg.current_limit_mode)
      msd_pkg::ILIM_OFF: ilim_active = 1'b0;
      msd_pkg::ILIM_INRUSH: ilim_active = !ctrl_reg.stall_en ||
                                          (state_reg == msd_pkg::ST_BLANK);
      default: ilim_active = 1'b1;
    endcase
  end

  assign drive_on = drive_f(dir_a, dir_b);

  // On time drives, off time and current limit recirculate on low sides
  always_comb begin
    if (state_reg == msd_pkg::ST_LATCHED) begin
      bridge_next = '0;
    end else if (drive_on == '0) begin
      bridge_next = '0;
    end else if ((ilim_active && cmp_sel) || (internal_pwm && !pwm_on)) begin
      bridge_next = drive_f(1'b1, 1'b1);
    end else begin
      bridge_next = drive_on;
    end
  end

  // Latched state, or dir_a and dir_b both low, turns the bridge off
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bridge_outputs <= '0;
    end else begin
      bridge_outputs <= bridge_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_stall_set;
    $rose(stall_reg) |-> $past(state_reg == msd_pkg::ST_ARMED && ctrl_reg.stall_en && cmp_sel);
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag set without cause");

  property p_stall_detect;
    (state_reg == msd_pkg::ST_ARMED && ctrl_reg.stall_en && cmp_sel) |=> stall_reg;
  endproperty
  a_stall_detect: assert property (p_stall_detect) else $error("stall missed");

  property p_clear;
    (clear_req && state_reg != msd_pkg::ST_ARMED) |=> !stall_reg && state_reg == msd_pkg::ST_BLANK;
  endproperty
  a_clear: assert property (p_clear) else $error("clear fault failed");

  property p_latch_off;
    (state_reg == msd_pkg::ST_LATCHED) |=> bridge_outputs == '0;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("bridge on while latched");

  property p_indicate_only;
    (state_reg == msd_pkg::ST_ARMED && ctrl_reg.stall_response_select && !restart)
      |=> state_reg == msd_pkg::ST_ARMED;
  endproperty
  a_indicate_only: assert property (p_indicate_only) else $error("latched in indicate mode");

  property p_fault_report;
    ##1 fault_out_n_oe == $past(stall_reg && ctrl_reg.stall_report_enable);
  endproperty
  a_fault_report: assert property (p_fault_report) else $error("fault output mismatch");

  property p_sample_spacing;
    sample_tick |=> !sample_tick [*8];
  endproperty
  a_sample_spacing: assert property (p_sample_spacing) else $error("sample strobe too close");

  property p_duty_step;
    (reg_active && !full_duty && $past(reg_active) && !$past(full_duty) && !$past(sample_tick))
      |-> $stable(duty_reg);
  endproperty
  a_duty_step: assert property (p_duty_step) else $error("duty moved off sample");

  property p_full_duty;
    full_duty |=> duty_reg == msd_pkg::DUTY_MAX;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not applied");

  property p_blank_hold;
    (state_reg == msd_pkg::ST_BLANK && blank_cnt_reg > 17'h00001) |=> state_reg != msd_pkg::ST_ARMED;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("armed before blank expiry");

endmodule

`default_nettype wire

// file: verification/msd_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side motor and sense comparators, levels set by the bench
module msd_motor_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire msd_pkg::msd_bridge_s bridge_outputs,
  input wire logic [1:0] load_level,
  input wire logic [7:0] volt_level,
  input wire logic [7:0] speed_level,
  output logic sense_ge_ext_ref,
  output logic sense_ge_int_ref,
  output logic [7:0] avg_voltage,
  output logic [7:0] speed_estimate
);
  // Comparator levels follow the commanded load; bit 0 external, bit 1 internal
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_ge_ext_ref <= 1'b0;
      sense_ge_int_ref <= 1'b0;
    end else begin
      sense_ge_ext_ref <= load_level[0];
      sense_ge_int_ref <= load_level[1];
    end
  end
  // A coasting bridge gives no speed signal, so the estimate drops to zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avg_voltage <= 8'h00;
      speed_estimate <= 8'h00;
    end else begin
      avg_voltage <= volt_level;
      speed_estimate <= (bridge_outputs == 4'h0) ? 8'h00 : speed_level;
    end
  end
endmodule
`default_nettype wire

// file: verification/motor_stall_detect_and_regulation_pwm_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motor_stall_detect_and_regulation_pwm_bench;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} msd_row_s;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ext_ge, int_ge, fault_o, fault_oe, er;
  logic dir_a = 1'b0, dir_b = 1'b0, over_sup = 1'b0, fault_rec = 1'b0, sleep_ex = 1'b0;
  logic [1:0] flt_cut;
  logic [1:0] load_level = 2'h0;
  logic [7:0] avg_v, spd;
  logic [7:0] volt_level = 8'h00;
  msd_pkg::msd_bridge_s bridge;
  int bad_count = 0, total_checks = 0, cyc = 0, on_n, rc_n, zero_n, per, t0;
  msd_row_s rows [13];

  msd_core DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_ge_ext_ref(ext_ge), .sense_ge_int_ref(int_ge),
    .direction_pin_a(dir_a), .direction_pin_b(dir_b), .target_over_supply(over_sup),
    .avg_voltage(avg_v), .speed_estimate(spd), .fault_recovered(fault_rec),
    .sleep_exit(sleep_ex), .bridge_outputs(bridge), .fault_out_n_o(fault_o),
    .fault_out_n_oe(fault_oe), .output_filter_cutoff(flt_cut));
  msd_motor_model u_motor (.sys_clk(sys_clk), .rst_b(rst_b), .bridge_outputs(bridge),
    .load_level(load_level), .volt_level(volt_level), .speed_level(8'h00),
    .sense_ge_ext_ref(ext_ge), .sense_ge_int_ref(int_ge), .avg_voltage(avg_v),
    .speed_estimate(spd));

  // Clock at 25 MHz
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h00000001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts drive, recirculation and all-off cycles of the bridge
  task automatic meas(input int n, input logic [3:0] pat);
    on_n = 0;
    rc_n = 0;
    zero_n = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (bridge === pat) on_n++;
      if (bridge === 4'h5) rc_n++;
      if (bridge === 4'h0) zero_n++;
    end
  endtask

  // Hang guard; the stall window alone takes about 123k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 200000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h000025F5, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h00000002, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
      '{1'b1, 8'h14, 32'hFFFFFFFF, 32'h0, 1'b1}, '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'b0},
      '{1'b0, 8'h0C, 32'h0, 32'h00000002, 1'b0}, '{1'b1, 8'h08, 32'hFFFFFFFF, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h00003FFF, 1'b0}, '{1'b1, 8'h04, 32'hFFFF0000, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}};
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Reset values, access kinds and the unmapped address
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chk(rd, rows[i].x);
    end
    apb(1'b1, 8'h00, 32'h0000C000);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, flt_cut}, 32'h00000003);
    chk({31'h0, fault_o}, 32'h00000000);
    // Manual PWM over both sources and both rates, input mode set to show it is ignored
    dir_b <= 1'b1;
    apb(1'b1, 8'h08, 32'h00001F00);
    for (int i = 0; i < 4; i++) begin
      per = i[1] ? 1000 : 500;
      apb(1'b1, 8'h00, 32'h00002A00 | (32'(i[0]) << 10) | (32'(i[1]) << 8));
      repeat (20) @(posedge sys_clk);
      meas(2 * per, i[0] ? 4'h9 : 4'h6);
      chk(on_n, 2 * ((125 * per) / 256));
      chk(rc_n, 2 * per - on_n);
    end
    // Current limit mode per code with the sense above the external reference
    load_level <= 2'h1;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'h00000E00 | (32'(m) << 4));
      repeat (20) @(posedge sys_clk);
      meas(1000, 4'h9);
      chk(on_n, (m == 0) ? 488 : 0);
    end
    load_level <= 2'h0;
    // Voltage regulation with the manual duty bit kept clear
    dir_a <= 1'b1;
    dir_b <= 1'b0;
    apb(1'b1, 8'h08, 32'h00000080);
    apb(1'b1, 8'h00, 32'h000000C0);
    apb(1'b0, 8'h0C, 32'h0);
    t0 = rd[15:8];
    chk({31'h0, rd[2]}, 32'h00000001);
    repeat (3120) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'((int'(rd[15:8]) - t0) inside {[9:11]}), 32'h00000001);
    volt_level <= 8'hFF;
    t0 = rd[15:8];
    repeat (1560) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'((int'(rd[15:8]) - t0) inside {[-6:-4]}), 32'h00000001);
    // Speed regulation with the estimate below target; start from the last duty read
    t0 = rd[15:8];
    apb(1'b1, 8'h00, 32'h00000080);
    repeat (1560) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'((int'(rd[15:8]) - t0) inside {[3:7]}), 32'h00000001);
    // Target above supply forces full duty
    apb(1'b1, 8'h00, 32'h000000C0);
    over_sup <= 1'b1;
    repeat (20) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h000000FF);
    meas(1000, 4'h9);
    chk(rc_n, 0);
    over_sup <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk({24'h0, rd[15:8]}, 32'h00000000);
    // The inrush code plus the 5 ms floor sets the window
    // Stall: restart the shortest window, sense high while blanked
    apb(1'b1, 8'h00, 32'h00000005);
    fault_rec <= 1'b1;
    @(posedge sys_clk);
    fault_rec <= 1'b0;
    sleep_ex <= 1'b1;
    @(posedge sys_clk);
    sleep_ex <= 1'b0;
    t0 = cyc;
    load_level <= 2'h1;
    repeat (300) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h00000002);
    load_level <= 2'h0;
    do begin
      apb(1'b0, 8'h0C, 32'h0);
    end while (rd[1] === 1'b1 && cyc < t0 + 130000);
    chk(32'((cyc - t0) inside {[122878:122900]}), 32'h00000001);
    // Internal level is ignored until it is selected
    load_level <= 2'h2;
    repeat (50) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[0]}, 32'h00000000);
    apb(1'b1, 8'h00, 32'h00000007);
    repeat (10) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[0]}, 32'h00000001);
    meas(100, 4'h0);
    chk(zero_n, 0);
    chk({31'h0, fault_oe}, 32'h00000000);
    apb(1'b1, 8'h00, 32'h0000000F);
    repeat (5) @(posedge sys_clk);
    chk({31'h0, fault_oe}, 32'h00000001);
    load_level <= 2'h0;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, rd[0]}, 32'h00000001);
    // Latched response: bridge stays off after the current falls
    apb(1'b1, 8'h00, 32'h0000000B);
    load_level <= 2'h2;
    repeat (10) @(posedge sys_clk);
    load_level <= 2'h0;
    repeat (20) @(posedge sys_clk);
    meas(50, 4'h0);
    chk(zero_n, 50);
    apb(1'b1, 8'h10, 32'h00000001);
    apb(1'b0, 8'h0C, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h00000002);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, fault_oe}, 32'h00000000);
    finish_test();
  end
endmodule
`default_nettype wire
